// ===== brt_map.svh
// Purpose: Address map, field positions, reset values and counts of the BCD clock.
// Assumes: Included by the package and by every design file that needs a constant.
// Notes: Definitions only.
`ifndef BRT_MAP_SVH
`define BRT_MAP_SVH
`define BRT_SLAVE_ADDR 7'h68
`define BRT_A_SEC 6'h00
`define BRT_A_MIN 6'h01
`define BRT_A_HOUR 6'h02
`define BRT_A_DAY 6'h03
`define BRT_A_DATE 6'h04
`define BRT_A_MONTH 6'h05
`define BRT_A_YEAR 6'h06
`define BRT_A_CTRL 6'h07
`define BRT_A_RAM 6'h08
`define BRT_A_LAST 6'h3F
`define BRT_PTR_STEP 6'h01
`define BRT_RAM_DEPTH 56
`define BRT_TK_REGS 7
`define BRT_B_HALT 7
`define BRT_B_H12 6
`define BRT_B_PM 5
`define BRT_B_OUT 7
`define BRT_B_WAVE_EN 4
`define BRT_RS_HI 1
`define BRT_RS_LO 0
`define BRT_RS_1HZ 2'h0
`define BRT_RS_4K 2'h1
`define BRT_RS_8K 2'h2
`define BRT_RS_32K 2'h3
`define BRT_M_WIDE 8'hFF
`define BRT_M_MIN 8'h7F
`define BRT_M_DAY 8'h07
`define BRT_M_DATE 8'h3F
`define BRT_M_MONTH 8'h1F
`define BRT_M_CTRL 8'h93
`define BRT_RST_SEC 8'h80
`define BRT_RST_CTRL 8'h03
`define BRT_RST_PINS 12'h333
`define BRT_I_SCL 0
`define BRT_I_SDA 1
`define BRT_I_OSC 2
`define BRT_I_PF 3
`define BRT_NSYNC 4
`define BRT_NBITS 4'h8
`define BRT_BIT_STEP 4'h1
`define BRT_DIV_W 15
`define BRT_DIV_STEP 15'h0001
`define BRT_DIV_LAST 15'h7FFF
`define BRT_DIV_1HZ 14
`define BRT_DIV_4K 2
`define BRT_DIV_8K 1
`define BRT_BCD_NINE 4'h9
`define BRT_BCD_STEP 4'h1
`define BRT_BCD_00 8'h00
`define BRT_BCD_01 8'h01
`define BRT_BCD_07 8'h07
`define BRT_BCD_11 8'h11
`define BRT_BCD_12 8'h12
`define BRT_BCD_23 8'h23
`define BRT_BCD_28 8'h28
`define BRT_BCD_29 8'h29
`define BRT_BCD_30 8'h30
`define BRT_BCD_31 8'h31
`define BRT_BCD_59 8'h59
`define BRT_BCD_99 8'h99
`define BRT_FEB 8'h02
`define BRT_APR 8'h04
`define BRT_JUN 8'h06
`define BRT_SEP 8'h09
`define BRT_NOV 8'h11
`endif

// ===== brt_pkg.sv
// Purpose: Types shared by the BCD clock design.
// Assumes: brt_map.svh supplies the widths.
// Notes: All state of the system domain except the user memory and its read register is one packed struct.
`include "brt_map.svh"
package brt_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK} brt_state_e;
  typedef struct packed {
    logic [`BRT_NSYNC-1:0] sync1;
    logic [`BRT_NSYNC-1:0] sync2;
    logic [`BRT_NSYNC-1:0] dly;
    brt_state_e state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic first;
    logic go;
    logic [5:0] ptr;
    logic sda_oe;
    logic [`BRT_TK_REGS-1:0][7:0] tk;
    logic [`BRT_TK_REGS-1:0][7:0] shadow;
    logic [7:0] ctrl;
    logic [`BRT_DIV_W-1:0] div;
    logic sqw_oe;
  } brt_sys_s;
endpackage : brt_pkg

// ===== brt_ram.sv
// Purpose: General-purpose byte memory behind the clock registers.
// Assumes: Indices are already rebased to zero and stay below the depth.
// Notes: Read data come out of a register, one cycle after the index.
`timescale 1ns/1ns
`include "brt_map.svh"
module brt_ram (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [5:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [5:0] rd_idx_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [0:`BRT_RAM_DEPTH-1];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_idx_i];
  end
endmodule : brt_ram

// ===== brt_rtc.sv
// Purpose: BCD clock and calendar with user RAM and square-wave pin, reached over a two-wire serial slave.
// Assumes: Bus pins, oscillator and power-fail level are asynchronous and are sampled on CLK_SYS_I.
// Notes: Open-drain pins only ever drive low; the enables carry the data.
`timescale 1ns/1ns
`include "brt_map.svh"
////////////////////////////////////////////////////////////////////////////////
module brt_rtc (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic OSC_I,
  input wire logic POWER_FAIL_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic SQUARE_WAVE_PIN_O,
  output logic SQUARE_WAVE_PIN_OE_O
);
  import brt_pkg::*;

  brt_sys_s r_r;
  brt_sys_s r_nxt;
  logic wr_en;
  logic tick;
  logic hc;
  logic rb;
  logic lvl;
  logic [8:0] s;
  logic [7:0] hv;
  logic [7:0] rd_byte;
  logic [7:0] ram_rdata;
  logic [5:0] ram_idx;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic pfail;
  logic osc_edge;
  logic halted;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == `BRT_BCD_NINE) begin
      bcd_inc = {v[7:4] + `BRT_BCD_STEP, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + `BRT_BCD_STEP};
    end
  endfunction : bcd_inc
  // Returns the carry above the next value.
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
    bcd_step = (v == last) ? {1'b1, first} : {1'b0, bcd_inc(v)};
  endfunction : bcd_step
  function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
    if (m == `BRT_FEB) begin
      last_date = (!y[0] && (y[1] == y[4])) ? `BRT_BCD_29 : `BRT_BCD_28;
    end else if (m == `BRT_APR || m == `BRT_JUN || m == `BRT_SEP || m == `BRT_NOV) begin
      last_date = `BRT_BCD_30;
    end else begin
      last_date = `BRT_BCD_31;
    end
  endfunction : last_date
  function automatic logic [7:0] wr_mask(input logic [5:0] a);
    unique case (a)
      `BRT_A_MIN, `BRT_A_HOUR: wr_mask = `BRT_M_MIN;
      `BRT_A_DAY: wr_mask = `BRT_M_DAY;
      `BRT_A_DATE: wr_mask = `BRT_M_DATE;
      `BRT_A_MONTH: wr_mask = `BRT_M_MONTH;
      `BRT_A_CTRL: wr_mask = `BRT_M_CTRL;
      default: wr_mask = `BRT_M_WIDE;
    endcase
  endfunction : wr_mask
  ////////////////////////////////////////////////////////////////////////////////
  // Events seen on the synchronised pins; the first sync stage is never read here.
  assign scl_rise = r_r.sync2[`BRT_I_SCL] && !r_r.dly[`BRT_I_SCL];
  assign scl_fall = !r_r.sync2[`BRT_I_SCL] && r_r.dly[`BRT_I_SCL];
  assign start_det = r_r.sync2[`BRT_I_SCL] && r_r.dly[`BRT_I_SCL] && r_r.dly[`BRT_I_SDA] && !r_r.sync2[`BRT_I_SDA];
  assign stop_det = r_r.sync2[`BRT_I_SCL] && r_r.dly[`BRT_I_SCL] && !r_r.dly[`BRT_I_SDA] && r_r.sync2[`BRT_I_SDA];
  assign pfail = r_r.sync2[`BRT_I_PF];
  assign osc_edge = r_r.sync2[`BRT_I_OSC] && !r_r.dly[`BRT_I_OSC];
  assign halted = r_r.tk[`BRT_A_SEC][`BRT_B_HALT];
  assign ram_idx = (r_r.ptr < `BRT_A_RAM) ? 6'h00 : 6'(r_r.ptr - `BRT_A_RAM);

  brt_ram u_ram (
    .clk_i(CLK_SYS_I),
    .wr_en_i(wr_en && (r_r.ptr >= `BRT_A_RAM)),
    .wr_idx_i(ram_idx),
    .wr_data_i(r_r.shreg),
    .rd_idx_i(ram_idx),
    .rd_data_o(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_nxt = r_r;
    wr_en = 1'b0;
    tick = 1'b0;
    hc = 1'b0;
    rb = 1'b0;
    lvl = 1'b0;
    s = '0;
    hv = '0;
    r_nxt.sync1 = {POWER_FAIL_I, OSC_I, SDA_I, SCL_I};
    r_nxt.sync2 = r_r.sync1;
    r_nxt.dly = r_r.sync2;
    if (r_r.ptr < `BRT_A_CTRL) begin
      rd_byte = r_r.shadow[r_r.ptr[2:0]];
    end else if (r_r.ptr == `BRT_A_CTRL) begin
      rd_byte = r_r.ctrl;
    end else begin
      rd_byte = ram_rdata;
    end
    // Serial slave.
    if (pfail) begin
      r_nxt.state = ST_IDLE;
      r_nxt.sda_oe = 1'b0;
      r_nxt.ptr = `BRT_A_SEC;
      r_nxt.bitcnt = '0;
    end else if (start_det) begin
      r_nxt.state = ST_ADDR;
      r_nxt.bitcnt = '0;
      r_nxt.sda_oe = 1'b0;
      r_nxt.shadow = r_r.tk;
    end else if (stop_det) begin
      r_nxt.state = ST_IDLE;
      r_nxt.sda_oe = 1'b0;
    end else begin
      unique case (r_r.state)
        ST_IDLE: begin
          r_nxt.state = ST_IDLE;
        end
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            r_nxt.shreg = {r_r.shreg[6:0], r_r.sync2[`BRT_I_SDA]};
            r_nxt.bitcnt = r_r.bitcnt + `BRT_BIT_STEP;
          end else if (scl_fall && r_r.bitcnt == `BRT_NBITS) begin
            r_nxt.bitcnt = '0;
            if (r_r.state == ST_ADDR) begin
              if (r_r.shreg[7:1] == `BRT_SLAVE_ADDR) begin
                r_nxt.sda_oe = 1'b1;
                r_nxt.rw = r_r.shreg[0];
                r_nxt.state = ST_ADDR_ACK;
              end else begin
                r_nxt.state = ST_IDLE;
              end
            end else begin
              r_nxt.sda_oe = 1'b1;
              r_nxt.state = ST_WR_ACK;
              if (r_r.first) begin
                r_nxt.ptr = r_r.shreg[5:0];
                r_nxt.first = 1'b0;
              end else begin
                wr_en = 1'b1;
                r_nxt.ptr = r_r.ptr + `BRT_PTR_STEP;
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            r_nxt.sda_oe = 1'b0;
            if (r_r.rw) begin
              r_nxt.shreg = rd_byte;
              r_nxt.sda_oe = !rd_byte[7];
              r_nxt.state = ST_RD_BYTE;
            end else begin
              r_nxt.first = 1'b1;
              r_nxt.state = ST_WR_BYTE;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            r_nxt.sda_oe = 1'b0;
            r_nxt.state = ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (scl_rise) begin
            r_nxt.bitcnt = r_r.bitcnt + `BRT_BIT_STEP;
          end else if (scl_fall) begin
            if (r_r.bitcnt == `BRT_NBITS) begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.bitcnt = '0;
              r_nxt.go = 1'b0;
              r_nxt.ptr = r_r.ptr + `BRT_PTR_STEP;
              r_nxt.state = ST_RD_ACK;
            end else begin
              r_nxt.shreg = {r_r.shreg[6:0], 1'b0};
              r_nxt.sda_oe = !r_r.shreg[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            if (r_r.sync2[`BRT_I_SDA]) begin
              r_nxt.state = ST_IDLE;
            end else begin
              r_nxt.go = 1'b1;
            end
          end else if (scl_fall && r_r.go) begin
            r_nxt.shreg = rd_byte;
            r_nxt.sda_oe = !rd_byte[7];
            r_nxt.go = 1'b0;
            r_nxt.state = ST_RD_BYTE;
          end
        end
      endcase
    end
    // Divider: the second ends as its top bit falls.
    if (osc_edge && !halted) begin
      r_nxt.div = r_r.div + `BRT_DIV_STEP;
      tick = (r_r.div == `BRT_DIV_LAST);
    end
    if (tick) begin
      s = bcd_step({1'b0, r_r.tk[`BRT_A_SEC][6:0]}, `BRT_BCD_59, `BRT_BCD_00);
      r_nxt.tk[`BRT_A_SEC][6:0] = s[6:0];
      if (s[8]) begin
        s = bcd_step(r_r.tk[`BRT_A_MIN], `BRT_BCD_59, `BRT_BCD_00);
        r_nxt.tk[`BRT_A_MIN] = s[7:0];
        if (s[8]) begin
          if (r_r.tk[`BRT_A_HOUR][`BRT_B_H12]) begin
            hv = {3'h0, r_r.tk[`BRT_A_HOUR][4:0]};
            if (hv == `BRT_BCD_11) begin
              r_nxt.tk[`BRT_A_HOUR][`BRT_B_PM] = !r_r.tk[`BRT_A_HOUR][`BRT_B_PM];
              hc = r_r.tk[`BRT_A_HOUR][`BRT_B_PM];
              hv = `BRT_BCD_12;
            end else if (hv == `BRT_BCD_12) begin
              hv = `BRT_BCD_01;
            end else begin
              hv = bcd_inc(hv);
            end
            r_nxt.tk[`BRT_A_HOUR][4:0] = hv[4:0];
          end else begin
            s = bcd_step({2'h0, r_r.tk[`BRT_A_HOUR][5:0]}, `BRT_BCD_23, `BRT_BCD_00);
            r_nxt.tk[`BRT_A_HOUR][5:0] = s[5:0];
            hc = s[8];
          end
          if (hc) begin
            s = bcd_step(r_r.tk[`BRT_A_DAY], `BRT_BCD_07, `BRT_BCD_01);
            r_nxt.tk[`BRT_A_DAY] = s[7:0];
            s = bcd_step(r_r.tk[`BRT_A_DATE], last_date(r_r.tk[`BRT_A_MONTH], r_r.tk[`BRT_A_YEAR]), `BRT_BCD_01);
            r_nxt.tk[`BRT_A_DATE] = s[7:0];
            if (s[8]) begin
              s = bcd_step(r_r.tk[`BRT_A_MONTH], `BRT_BCD_12, `BRT_BCD_01);
              r_nxt.tk[`BRT_A_MONTH] = s[7:0];
              if (s[8]) begin
                s = bcd_step(r_r.tk[`BRT_A_YEAR], `BRT_BCD_99, `BRT_BCD_00);
                r_nxt.tk[`BRT_A_YEAR] = s[7:0];
              end
            end
          end
        end
      end
    end
    // Writes land after counting, so a write beats a tick in the same cycle.
    if (wr_en && r_r.ptr < `BRT_A_CTRL) begin
      r_nxt.tk[r_r.ptr[2:0]] = r_r.shreg & wr_mask(r_r.ptr);
      if (r_r.ptr == `BRT_A_SEC) begin
        r_nxt.div = '0;
      end
    end
    if (wr_en && r_r.ptr == `BRT_A_CTRL) begin
      r_nxt.ctrl = r_r.shreg & wr_mask(r_r.ptr);
    end
    // Square-wave pin.
    unique case (r_r.ctrl[`BRT_RS_HI:`BRT_RS_LO])
      `BRT_RS_1HZ: rb = r_r.div[`BRT_DIV_1HZ];
      `BRT_RS_4K: rb = r_r.div[`BRT_DIV_4K];
      `BRT_RS_8K: rb = r_r.div[`BRT_DIV_8K];
      `BRT_RS_32K: rb = r_r.dly[`BRT_I_OSC] && !halted;
    endcase
    lvl = r_r.ctrl[`BRT_B_WAVE_EN] ? rb : r_r.ctrl[`BRT_B_OUT];
    r_nxt.sqw_oe = !lvl;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      r_r <= '0;
      r_r.state <= ST_IDLE;
      {r_r.sync1, r_r.sync2, r_r.dly} <= `BRT_RST_PINS;
      r_r.tk[`BRT_A_SEC] <= `BRT_RST_SEC;
      r_r.tk[`BRT_A_DAY] <= `BRT_BCD_01;
      r_r.tk[`BRT_A_DATE] <= `BRT_BCD_01;
      r_r.tk[`BRT_A_MONTH] <= `BRT_BCD_01;
      r_r.ctrl <= `BRT_RST_CTRL;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign SDA_O = 1'b0;
  assign SDA_OE_O = r_r.sda_oe;
  assign SQUARE_WAVE_PIN_O = 1'b0;
  assign SQUARE_WAVE_PIN_OE_O = r_r.sqw_oe;

  ////////////////////////////////////////////////////////////////////////////////
  property p_ptr_wrap;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
    (wr_en && r_r.ptr == `BRT_A_LAST) |=> (r_r.ptr == `BRT_A_SEC);
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap to zero");
  property p_halt_hold;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
    (halted && !wr_en) |=> $stable(r_r.div);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("divider moved while halted");
  property p_div_reset;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
    (wr_en && r_r.ptr == `BRT_A_SEC) |=> (r_r.div == '0);
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider not cleared by seconds write");
  property p_tick_fall;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
    (tick && !wr_en) |=> $fell(r_r.div[`BRT_DIV_1HZ]);
  endproperty
  a_tick_fall: assert property (p_tick_fall) else $error("second advanced off the falling edge");
  property p_shadow;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
    (start_det && !pfail) |=> (r_r.shadow == $past(r_r.tk));
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow not loaded at start");
  property p_pfail;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
    pfail |=> (r_r.state == ST_IDLE && r_r.ptr == `BRT_A_SEC && !SDA_OE_O);
  endproperty
  a_pfail: assert property (p_pfail) else $error("bus not aborted on power fail");
  property p_static_out;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
    !r_r.ctrl[`BRT_B_WAVE_EN] |=> (SQUARE_WAVE_PIN_OE_O == !$past(r_r.ctrl[`BRT_B_OUT]));
  endproperty
  a_static_out: assert property (p_static_out) else $error("pin does not follow level bit");
  property p_weekday;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
    (tick && hc && !wr_en && r_r.tk[`BRT_A_DAY] == `BRT_BCD_07) |=> (r_r.tk[`BRT_A_DAY] == `BRT_BCD_01);
  endproperty
  a_weekday: assert property (p_weekday) else $error("weekday did not return to one");
  property p_zero_bits;
    @(posedge CLK_SYS_I) disable iff (SRST_I)
    ((r_r.tk[`BRT_A_DAY] & ~`BRT_M_DAY) == '0) && ((r_r.ctrl & ~`BRT_M_CTRL) == '0);
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bit is set");
endmodule : brt_rtc

// ===== brt_bus_master.sv
// Purpose: Two-wire bus master that stands in for the controller beside the clock.
// Assumes: Both lines are open drain with pull-ups; sda_i is the wired level of the data line.
// Notes: Q is a quarter bit period in system cycles; the default keeps to standard mode.
`timescale 1ns/1ns
module brt_bus_master #(
  parameter int Q = 63
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wq();
    repeat (Q) @(posedge clk_i);
  endtask : wq

  // Data only changes while the clock is low; the line is sampled mid-high.
  task automatic bit_io(input logic b, output logic s);
    sda_low_o <= ~b;
    wq();
    scl_o <= 1'b1;
    wq();
    s = sda_i;
    wq();
    scl_o <= 1'b0;
    wq();
  endtask : bit_io

  task automatic start();
    sda_low_o <= 1'b0;
    wq();
    scl_o <= 1'b1;
    wq();
    sda_low_o <= 1'b1;
    wq();
    scl_o <= 1'b0;
    wq();
  endtask : start

  task automatic stop();
    sda_low_o <= 1'b1;
    wq();
    scl_o <= 1'b1;
    wq();
    sda_low_o <= 1'b0;
    wq();
  endtask : stop

  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : put

  task automatic get(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~more, s);
  endtask : get

  ////////////////////////////////////////////////////////////////////////////////
  // Pointer byte then data bytes; nak counts the bytes left unacknowledged.
  task automatic write_regs(input logic [7:0] ptr, input logic [7:0] data[$], output int nak);
    logic a;
    nak = 0;
    start();
    put(8'hD0, a);
    nak += a ? 0 : 1;
    put(ptr, a);
    nak += a ? 0 : 1;
    foreach (data[i]) begin
      put(data[i], a);
      nak += a ? 0 : 1;
    end
    stop();
  endtask : write_regs

  // Reads from the current pointer; the last byte is not acknowledged.
  task automatic read_regs(input int n, output logic [7:0] got[$], output int nak);
    logic a;
    logic [7:0] b;
    got = '{};
    start();
    put(8'hD1, a);
    nak = a ? 0 : 1;
    for (int i = 0; i < n; i++) begin
      get(i < n - 1, b);
      got.push_back(b);
    end
    stop();
  endtask : read_regs
endmodule : brt_bus_master

// ===== tb_top.sv
// Purpose: Self-checking bench for the BCD clock with user memory and square-wave pin.
// Assumes: The oscillator comes from a free-running link clock of 32 ns, divided by four.
// Notes: The bus master runs a short bit period to keep the run brief.
`timescale 1ns/1ns
module tb_top;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic lk_clk = 1'b0;
  logic [1:0] osc_div = 2'h0;
  logic rst = 1'b1;
  logic pf = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_o;
  logic sda_oe;
  logic sqw_o;
  logic sqw_oe;
  wire logic sda = ~sda_low & (sda_oe ? sda_o : 1'b1);
  wire logic pin = sqw_oe ? sqw_o : 1'b1;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  always #20 clk = ~clk;
  always #16 lk_clk = ~lk_clk;
  always @(posedge lk_clk) begin
    osc_div <= osc_div + 2'h1;
  end

  brt_rtc DUT (.CLK_SYS_I(clk), .SRST_I(rst), .OSC_I(osc_div[1]), .POWER_FAIL_I(pf), .SCL_I(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .SQUARE_WAVE_PIN_O(sqw_o),
    .SQUARE_WAVE_PIN_OE_O(sqw_oe));
  brt_bus_master #(.Q(10)) u_mst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk

  task automatic chkr(input string what, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
      miscompares++;
    end
  endtask : chkr

  task automatic rd_from(input logic [7:0] p, input int n, output logic [7:0] got[$]);
    int nak;
    u_mst.write_regs(p, '{}, nak);
    chk("pointer write nak", 8'h00, 8'(nak));
    u_mst.read_regs(n, got, nak);
    chk("read nak", 8'h00, 8'(nak));
  endtask : rd_from

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    int nak;
    u_mst.write_regs(p, '{d}, nak);
    chk("write nak", 8'h00, 8'(nak));
  endtask : wr

  // Counts rising edges of the pin over 40 oscillator periods, sampled away from the launching edge.
  task automatic rises(output int n);
    logic prev;
    n = 0;
    prev = pin;
    repeat (128) begin
      @(negedge clk);
      if (pin === 1'b1 && prev === 1'b0) n++;
      prev = pin;
    end
  endtask : rises

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    logic [7:0] exp [8] = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h03};
    logic [7:0] got[$];
    int nak;
    chk("pin after reset", 8'h00, {7'h00, pin});
    u_mst.read_regs(8, got, nak);
    chk("read nak", 8'h00, 8'(nak));
    foreach (exp[i]) chk("reset register", exp[i], got[i]);
  endtask : t_reset_values

  task automatic t_bad_address();
    logic [7:0] adr [3] = '{8'hA0, 8'hD2, 8'h50};
    logic a;
    foreach (adr[i]) begin
      u_mst.start();
      u_mst.put(adr[i], a);
      u_mst.stop();
      chk("ack to foreign address", 8'h00, {7'h00, a});
    end
  endtask : t_bad_address

  task automatic t_power_fail();
    logic [7:0] got[$];
    logic a;
    int nak;
    wr(8'h20, 8'h5A);
    u_mst.write_regs(8'h20, '{}, nak);
    chk("pointer write nak", 8'h00, 8'(nak));
    pf <= 1'b1;
    repeat (8) @(posedge clk);
    u_mst.start();
    u_mst.put(8'hD0, a);
    u_mst.stop();
    chk("ack during power fail", 8'h00, {7'h00, a});
    pf <= 1'b0;
    repeat (8) @(posedge clk);
    u_mst.read_regs(1, got, nak);
    chk("pointer after power fail", 8'h80, got[0]);
    chk("read nak after power fail", 8'h00, 8'(nak));
    rd_from(8'h20, 1, got);
    chk("ram kept over power fail", 8'h5A, got[0]);
  endtask : t_power_fail

  task automatic t_ram_wrap();
    logic [7:0] got[$];
    int nak;
    u_mst.write_regs(8'h3E, '{8'hAA, 8'h55, 8'h80}, nak);
    chk("wrap write nak", 8'h00, 8'(nak));
    rd_from(8'h3E, 4, got);
    chk("ram 3Eh", 8'hAA, got[0]);
    chk("ram 3Fh", 8'h55, got[1]);
    chk("seconds after wrap", 8'h80, got[2]);
    chk("minutes after wrap", 8'h00, got[3]);
  endtask : t_ram_wrap

  task automatic t_hours_masks();
    logic [7:0] exp [6] = '{8'h72, 8'h01, 8'h01, 8'h01, 8'h00, 8'h93};
    logic [7:0] got[$];
    wr(8'h02, 8'h72);
    wr(8'h07, 8'hFF);
    rd_from(8'h02, 6, got);
    foreach (exp[i]) chk("register after masked write", exp[i], got[i]);
    wr(8'h02, 8'h23);
    rd_from(8'h02, 1, got);
    chk("hours in 24-hour mode", 8'h23, got[0]);
  endtask : t_hours_masks

  task automatic t_square_wave();
    int lo [4] = '{0, 4, 9, 39};
    int hi [4] = '{0, 6, 11, 41};
    int n;
    wr(8'h07, 8'h80);
    chk("static high level", 8'h01, {7'h00, pin});
    wr(8'h00, 8'h00);
    wr(8'h07, 8'h00);
    chk("static low level", 8'h00, {7'h00, pin});
    for (int r = 0; r < 4; r++) begin
      wr(8'h07, 8'h10 | 8'(r));
      rises(n);
      chkr("square wave rises", lo[r], hi[r], n);
    end
    wr(8'h00, 8'h80);
    wr(8'h07, 8'h11);
    rises(n);
    chkr("rises while halted", 0, 0, n);
  endtask : t_square_wave

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      $display("wrong value cycle count expected below %0d seen %0d", LIMIT, cycles);
      miscompares++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    t_reset_values();
    t_bad_address();
    t_power_fail();
    t_ram_wrap();
    t_hours_masks();
    t_square_wave();
    test_done();
  end
endmodule : tb_top
